// File: hw/mstr_cfg.svh
`ifndef MSTR_CFG_SVH
`define MSTR_CFG_SVH
// ==================================================
// Register offsets (word index on the plain port)
`define MSTR_ADDR_CTRL      4'h0
`define MSTR_ADDR_CURRENT   4'h1
`define MSTR_ADDR_STEP      4'h2
`define MSTR_ADDR_STATUS    4'h3
`define MSTR_ADDR_POSITION  4'h4
// ==================================================
// Control register fields
`define MSTR_CTRL_BRIDGE_EN 0
`define MSTR_CTRL_DIR_INV   1
`define MSTR_CTRL_RH_INV    2
`define MSTR_CTRL_BOOST     3
`define MSTR_CTRL_SLEEP     4
// Current register fields: run [3:0], hold [7:4]
`define MSTR_CUR_RUN_LSB    0
`define MSTR_CUR_HOLD_LSB   4
// Step register fields: resolution [2:0], soft request bit 3, pin override bit 4
`define MSTR_STEP_RES_LSB   0
`define MSTR_STEP_SOFT      3
`define MSTR_STEP_USE_REG   4
// Status register fields
`define MSTR_ST_RH_PIN      0
`define MSTR_ST_DIR_PIN     1
`define MSTR_ST_BOOST_ACT   2
`define MSTR_ST_RUN_MODE    3
`define MSTR_ST_DIAG_OFF    4
// ==================================================
// Reset values
`define MSTR_RST_CTRL       8'h00
`define MSTR_RST_CURRENT    8'h00
`define MSTR_RST_STEP       8'h00
`define MSTR_RST_POSITION   7'h00
// ==================================================
// Timing: PWM period 50 us at 125 MHz
`define MSTR_CLK_MHZ        125
`define MSTR_PWM_PERIOD_US  50
`define MSTR_PWM_CYCLES     (`MSTR_PWM_PERIOD_US * `MSTR_CLK_MHZ)
// Peak currents in mA, unboosted and boosted
`define MSTR_IMAX_MA        800
`define MSTR_IBOOST_MA      1100
`endif

// File: hw/mstr_pkg.sv
package mstr_pkg;
   typedef logic [3:0] mstr_level_t;
   typedef logic [2:0] mstr_res_t;
   typedef logic [6:0] mstr_pos_t;
   typedef logic [10:0] mstr_ma_t;
   typedef enum logic [1:0] {MSTR_IDLE, MSTR_PEND, MSTR_DONE} mstr_state_t;
endpackage

// File: hw/mstr_step_if.sv
interface mstr_step_if;
   import mstr_pkg::*;
   logic      step;
   logic      dir_up;
   mstr_res_t res;
   mstr_pos_t pos;
   modport src (output step, output dir_up, output res, input pos);
   modport dst (input step, input dir_up, input res, output pos);
endinterface

// File: hw/mstr_translator.sv
module mstr_translator (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_ce,
   mstr_step_if.dst stp
);
   import mstr_pkg::*;
`include "mstr_cfg.svh"
   mstr_pos_t pos_r;
   mstr_pos_t pos_nxt;
   mstr_pos_t inc;

   // Increment per resolution; full step modes move a quarter turn
   function automatic mstr_pos_t step_size(input mstr_res_t r);
      case (r)
         3'h0:    step_size = 7'h01;
         3'h1:    step_size = 7'h02;
         3'h2:    step_size = 7'h04;
         3'h3:    step_size = 7'h08;
         3'h4:    step_size = 7'h10;
         default: step_size = 7'h20;
      endcase
   endfunction

   assign inc     = step_size(stp.res);
   assign pos_nxt = stp.dir_up ? pos_r + inc : pos_r - inc;
   assign stp.pos = pos_r;

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         pos_r <= `MSTR_RST_POSITION;
      end else if (i_ce && stp.step) begin
         pos_r <= pos_nxt;
      end
   end

   a_pos_moves: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && stp.step |=> pos_r != $past(pos_r))
      else $error("position did not move on step");
   a_pos_still: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      !stp.step |=> $stable(pos_r))
      else $error("position moved without step");
endmodule

// File: hw/mstr_current_sel.sv
module mstr_current_sel (
   input  wire logic             i_clk_sys,
   input  wire logic             i_resetn,
   input  wire logic             i_ce,
   input  wire logic             i_run,
   input  wire logic             i_boost,
   input  wire logic             i_pwm_start,
   input  wire mstr_pkg::mstr_level_t i_run_lvl,
   input  wire mstr_pkg::mstr_level_t i_hold_lvl,
   output logic                  o_zero_hold,
   output mstr_pkg::mstr_ma_t    o_target_ma
);
   import mstr_pkg::*;
`include "mstr_cfg.svh"
   mstr_ma_t tgt_r;
   mstr_ma_t tgt_nxt;
   mstr_ma_t base_ma;
   logic     zero_r;
   logic     zero_nxt;

   // run code table, hold is run shifted
   function automatic mstr_ma_t run_ma(input mstr_level_t c);
      case (c)
         4'h0: run_ma = 11'd59;   4'h1: run_ma = 11'd71;
         4'h2: run_ma = 11'd84;   4'h3: run_ma = 11'd100;
         4'h4: run_ma = 11'd119;  4'h5: run_ma = 11'd141;
         4'h6: run_ma = 11'd168;  4'h7: run_ma = 11'd200;
         4'h8: run_ma = 11'd238;  4'h9: run_ma = 11'd283;
         4'ha: run_ma = 11'd336;  4'hb: run_ma = 11'd400;
         4'hc: run_ma = 11'd476;  4'hd: run_ma = 11'd566;
         4'he: run_ma = 11'd673;  default: run_ma = 11'd800;
      endcase
   endfunction

   assign zero_nxt = !i_run && (i_hold_lvl == 4'h0);
   assign base_ma  = i_run ? run_ma(i_run_lvl) :
                     (zero_nxt ? 11'd0 : run_ma(i_hold_lvl - 4'h1));
   assign tgt_nxt  = i_boost ?
      11'((22'(base_ma) * 22'(`MSTR_IBOOST_MA) + 22'd400) / 22'(`MSTR_IMAX_MA)) : base_ma;
   assign o_zero_hold = zero_r;
   assign o_target_ma = tgt_r;

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         tgt_r  <= 11'h000;
         zero_r <= 1'b0;
      end else if (i_ce && i_pwm_start) begin
         tgt_r  <= tgt_nxt;
         zero_r <= zero_nxt;
      end
   end

   a_tgt_hold: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      !i_pwm_start |=> $stable(tgt_r))
      else $error("target changed mid period");
endmodule

// File: hw/mstr_top.sv
module mstr_top (
   input  wire logic         i_clk_sys,
   input  wire logic         i_resetn,
   input  wire logic         i_ce,
   input  wire logic         i_step_pulse_pin,
   input  wire logic         i_dir_pin,
   input  wire logic         i_run_hold_pin,
   input  wire logic         i_resolution_pin_lo,
   input  wire logic         i_resolution_pin_hi,
   input  wire logic         i_thermal_warning,
   input  wire logic [3:0]   i_addr,
   input  wire logic [7:0]   i_wdata,
   input  wire logic         i_wr,
   input  wire logic         i_rd,
   output logic [7:0]        o_rdata,
   output logic              o_bridge_drive,
   output logic              o_diag_enable,
   output logic              o_duty_zero,
   output logic [10:0]       o_target_ma,
   output logic [6:0]        o_translator_position
);
   import mstr_pkg::*;
`include "mstr_cfg.svh"

   // ==================================================
   // Pin synchronisers
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic       step_prev_r;
   wire  [4:0] pins_raw = {i_thermal_warning, i_resolution_pin_hi, i_resolution_pin_lo,
                           i_run_hold_pin, i_dir_pin};

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         sync1_r <= 5'h00;
         sync2_r <= 5'h00;
      end else if (i_ce) begin
         sync1_r <= pins_raw;
         sync2_r <= sync1_r;
      end
   end

   logic step_s1_r;
   logic step_s2_r;
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         step_s1_r   <= 1'b0;
         step_s2_r   <= 1'b0;
         step_prev_r <= 1'b0;
      end else if (i_ce) begin
         step_s1_r   <= i_step_pulse_pin;
         step_s2_r   <= step_s1_r;
         step_prev_r <= step_s2_r;
      end
   end

   wire dir_pin_s  = sync2_r[0];
   wire rh_pin_s   = sync2_r[1];
   wire res_lo_s   = sync2_r[2];
   wire res_hi_s   = sync2_r[3];
   wire thermal_s  = sync2_r[4];
   wire pin_edge   = step_s2_r & ~step_prev_r;

   // ==================================================
   // Registers
   logic [7:0] ctrl_r;
   logic [7:0] cur_r;
   logic [7:0] step_r;
   wire wr_ctrl = i_wr && (i_addr == `MSTR_ADDR_CTRL);
   wire wr_cur  = i_wr && (i_addr == `MSTR_ADDR_CURRENT);
   wire wr_step = i_wr && (i_addr == `MSTR_ADDR_STEP);

   wire bridge_enable         = ctrl_r[`MSTR_CTRL_BRIDGE_EN];
   wire rotation_sense_invert = ctrl_r[`MSTR_CTRL_DIR_INV];
   wire run_hold_invert       = ctrl_r[`MSTR_CTRL_RH_INV];
   wire boost_req             = ctrl_r[`MSTR_CTRL_BOOST];
   wire sleep                 = ctrl_r[`MSTR_CTRL_SLEEP];
   wire soft_step_request     = step_r[`MSTR_STEP_SOFT];

   // ==================================================
   // Mode and trigger decode
   // run mode is pin xor invert
   // sleep forces no run, no stepping
   wire run_mode   = (rh_pin_s ^ run_hold_invert) & ~sleep;
   wire dir_up     = dir_pin_s ^ rotation_sense_invert;
   // trigger is edge or soft request
   // both in one cycle make one step
   wire trigger    = pin_edge | soft_step_request;
   // bridge enable not in step path
   wire step_go    = trigger & run_mode;
   // soft request clears once consumed
   // Only a taken step clears it, so a request parked in hold survives a pin edge
   wire soft_done  = soft_step_request & step_go;

   mstr_res_t res_used_r;
   wire mstr_res_t pin_res = {1'b0, res_hi_s, res_lo_s};
   wire mstr_res_t res_sel = step_r[`MSTR_STEP_USE_REG] ?
                             step_r[`MSTR_STEP_RES_LSB +: 3] : pin_res;

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_r <= `MSTR_RST_CTRL;
         cur_r  <= `MSTR_RST_CURRENT;
      end else if (i_ce) begin
         if (wr_ctrl) ctrl_r <= i_wdata;
         if (wr_cur)  cur_r  <= i_wdata;
      end
   end

   // write lands before its own soft step
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         step_r <= `MSTR_RST_STEP;
      end else if (i_ce) begin
         if (wr_step)
            step_r <= i_wdata;
         else if (soft_done)
            step_r[`MSTR_STEP_SOFT] <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         res_used_r <= 3'h0;
      end else if (i_ce && trigger) begin
         res_used_r <= res_sel;
      end
   end

   // ==================================================
   // Step execution: one cycle after trigger so settings are latched
   logic step_go_r;
   logic dir_up_r;
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         step_go_r <= 1'b0;
         dir_up_r  <= 1'b0;
      end else if (i_ce) begin
         step_go_r <= step_go;
         dir_up_r  <= dir_up;
      end
   end

   mstr_step_if stp ();
   assign stp.step   = step_go_r & i_ce;
   assign stp.dir_up = dir_up_r;
   assign stp.res    = res_used_r;

   mstr_translator u_translator (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .i_ce      (i_ce),
      .stp       (stp)
   );

   // ==================================================
   // PWM period tick
   logic [15:0] pwm_cnt_r;
   wire pwm_start = (pwm_cnt_r == 16'h0000);
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         pwm_cnt_r <= 16'h0000;
      end else if (i_ce) begin
         pwm_cnt_r <= pwm_start ? 16'(`MSTR_PWM_CYCLES - 1) : pwm_cnt_r - 16'h0001;
      end
   end

   wire boost_act = boost_req & ~thermal_s;
   logic        zero_hold;
   mstr_ma_t    target_ma;

   mstr_current_sel u_current (
      .i_clk_sys   (i_clk_sys),
      .i_resetn    (i_resetn),
      .i_ce        (i_ce),
      .i_run       (run_mode),
      .i_boost     (boost_act),
      .i_pwm_start (pwm_start),
      .i_run_lvl   (cur_r[`MSTR_CUR_RUN_LSB +: 4]),
      .i_hold_lvl  (cur_r[`MSTR_CUR_HOLD_LSB +: 4]),
      .o_zero_hold (zero_hold),
      .o_target_ma (target_ma)
   );

   // ==================================================
   // Outputs and read port
   wire [7:0] status = {3'h0, zero_hold, run_mode, boost_act, dir_pin_s, rh_pin_s};
   wire [7:0] rd_mux = (i_addr == `MSTR_ADDR_CTRL)     ? ctrl_r :
                       (i_addr == `MSTR_ADDR_CURRENT)  ? cur_r  :
                       (i_addr == `MSTR_ADDR_STEP)     ? step_r :
                       (i_addr == `MSTR_ADDR_STATUS)   ? status :
                       (i_addr == `MSTR_ADDR_POSITION) ? {1'b0, stp.pos} : 8'h00;

   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata               <= 8'h00;
         o_bridge_drive        <= 1'b0;
         o_diag_enable         <= 1'b0;
         o_duty_zero           <= 1'b1;
         o_target_ma           <= 11'h000;
         o_translator_position <= 7'h00;
      end else if (i_ce) begin
         o_rdata               <= i_rd ? rd_mux : 8'h00;
         // bridges only when enabled and awake
         o_bridge_drive        <= bridge_enable & ~sleep;
         o_diag_enable         <= bridge_enable & ~sleep & ~zero_hold;
         o_duty_zero           <= ~bridge_enable | sleep | zero_hold;
         o_target_ma           <= target_ma;
         o_translator_position <= stp.pos;
      end
   end

   // ==================================================
   a_soft_clear: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && soft_step_request && run_mode && !wr_step |=> !soft_step_request)
      else $error("soft request not cleared");
   a_hold_no_step: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && !run_mode |=> !step_go_r)
      else $error("step taken in hold");
   a_one_per_edge: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      pin_edge && i_ce |=> !pin_edge)
      else $error("double edge");
   a_boost_thermal: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      thermal_s |-> !boost_act)
      else $error("boost during thermal warning");
   a_res_latched: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && !trigger |=> $stable(res_used_r))
      else $error("resolution changed without trigger");
   a_bridge_off: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && !bridge_enable |=> !o_bridge_drive)
      else $error("bridge driven while disabled");
   a_sleep_still: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      sleep |-> !step_go)
      else $error("step in sleep");
   a_pos_out: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce |=> o_translator_position == $past(stp.pos))
      else $error("position output stale");
   c_pin_step: cover property (@(posedge i_clk_sys) pin_edge && run_mode ##2 stp.step);
   c_soft_step: cover property (@(posedge i_clk_sys) wr_step && i_wdata[`MSTR_STEP_SOFT]
      ##[1:3] step_go_r);
   c_hold_trig: cover property (@(posedge i_clk_sys) trigger && !run_mode);
endmodule

// File: tb/mstr_mcu_model.sv
// ==================================================
// Controller side: step, direction, run/hold and resolution pins
module mstr_mcu_model (
   input  wire logic i_clk_sys,
   output logic      o_step_pulse_pin,
   output logic      o_dir_pin,
   output logic      o_run_hold_pin,
   output logic      o_resolution_pin_lo,
   output logic      o_resolution_pin_hi
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_step_pulse_pin = 1'b0;
      o_dir_pin = 1'b0;
      o_run_hold_pin = 1'b0;
      o_resolution_pin_lo = 1'b0;
      o_resolution_pin_hi = 1'b0;
   end

   // ==================================================
   // Pin step
   // pins settle apart from edge, low time spaces soft request
   task automatic step_pin(input logic dir, input logic [1:0] res);
      @(posedge i_clk_sys);
      o_dir_pin <= dir;
      {o_resolution_pin_hi, o_resolution_pin_lo} <= res;
      // Four cycles so the synchroniser sees settled levels first
      repeat (4) @(posedge i_clk_sys);
      o_step_pulse_pin <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      o_step_pulse_pin <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
   endtask

   task automatic set_rh(input logic v);
      @(posedge i_clk_sys);
      o_run_hold_pin <= v;
      repeat (4) @(posedge i_clk_sys);
   endtask
endmodule

// File: tb/mstr_top_tb.sv
module mstr_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mstr_pkg::*;

   logic        i_clk_sys = 1'b0;
   logic        i_resetn = 1'b0;
   logic        i_ce = 1'b0;
   logic        i_thermal_warning = 1'b0;
   logic [3:0]  i_addr = 4'h0;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [7:0]  o_rdata;
   logic        o_bridge_drive;
   logic        o_diag_enable;
   logic        o_duty_zero;
   logic [10:0] o_target_ma;
   logic [6:0]  o_translator_position;
   logic        step_pin;
   logic        dir_pin;
   logic        rh_pin;
   logic        res_lo;
   logic        res_hi;
   logic [7:0]  rd_q[$];
   mstr_pos_t   pos_q[$];
   mstr_pos_t   pos_exp = 7'h00;
   mstr_pos_t   pos_seen = 7'h00;
   logic        rd_d = 1'b0;
   logic        dir_inv = 1'b0;
   int          error_cnt = 0;
   int          checks = 0;
   int          seed = 24566;

   always #4 i_clk_sys = ~i_clk_sys;

   mstr_mcu_model mcu (.i_clk_sys(i_clk_sys), .o_step_pulse_pin(step_pin), .o_dir_pin(dir_pin),
      .o_run_hold_pin(rh_pin), .o_resolution_pin_lo(res_lo), .o_resolution_pin_hi(res_hi));

   mstr_top dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(i_ce),
      .i_step_pulse_pin(step_pin), .i_dir_pin(dir_pin), .i_run_hold_pin(rh_pin),
      .i_resolution_pin_lo(res_lo), .i_resolution_pin_hi(res_hi),
      .i_thermal_warning(i_thermal_warning), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_bridge_drive(o_bridge_drive),
      .o_diag_enable(o_diag_enable), .o_duty_zero(o_duty_zero), .o_target_ma(o_target_ma),
      .o_translator_position(o_translator_position));

   // ==================================================
   // Shared tasks
   task automatic cmp(input logic [10:0] got, input logic [10:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic close_out;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      rd_q.push_back(exp);
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
   endtask

   // Notes where the translator should land after one trigger
   task automatic exp_step(input logic up, input logic [2:0] res);
      int sz;
      sz = (res < 3'h5) ? (1 << res) : 32;
      pos_exp = up ? pos_exp + 7'(sz) : pos_exp - 7'(sz);
      pos_q.push_back(pos_exp);
   endtask

   task automatic wait_pwm;
      // Target loads only at a period start, so wait one full period
      repeat (6260) @(posedge i_clk_sys);
   endtask

   // ==================================================
   // Result watcher
   always @(posedge i_clk_sys) rd_d <= i_rd;

   always @(negedge i_clk_sys) begin
      if (rd_d) begin
         cmp({3'h0, o_rdata}, {3'h0, rd_q.pop_front()}, "read data");
      end
      if (i_resetn && o_translator_position !== pos_seen) begin
         pos_seen = o_translator_position;
         if (pos_q.size() == 0) begin
            cmp({4'h0, pos_seen}, 11'h7ff, "unexpected step");
         end else begin
            cmp({4'h0, pos_seen}, {4'h0, pos_q.pop_front()}, "position");
         end
      end
   end

   // ==================================================
   // Scenarios
   initial begin
      logic d;
      repeat (2) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      i_ce <= 1'b1;
      rd_reg(4'h0, 8'h00);
      rd_reg(4'h1, 8'h00);
      rd_reg(4'h2, 8'h00);
      rd_reg(4'h4, 8'h00);
      rd_reg(4'h3, 8'h10);
      rd_reg(4'h9, 8'h00);
      cmp({10'h0, o_duty_zero}, 11'h1, "duty zero at reset");
      mcu.step_pin(1'b1, 2'h0);
      wr_reg(4'h2, 8'h08);
      rd_reg(4'h2, 8'h08);
      exp_step(1'b1, 3'h0);
      mcu.set_rh(1'b1);
      repeat (8) @(posedge i_clk_sys);
      rd_reg(4'h2, 8'h00);
      rd_reg(4'h3, 8'h1b);
      for (int i = 0; i < 4; i++) begin
         d = 1'($random(seed));
         exp_step(d ^ dir_inv, 3'(i));
         mcu.step_pin(d, 2'(i));
      end
      for (int i = 0; i < 8; i++) begin
         dir_inv = 1'($random(seed));
         wr_reg(4'h0, {6'h0, dir_inv, 1'b0});
         exp_step(dir_pin ^ dir_inv, 3'(i));
         wr_reg(4'h2, {5'h03, 3'(i)});
         repeat (8) @(posedge i_clk_sys);
      end
      wr_reg(4'h2, 8'h10);
      repeat (8) @(posedge i_clk_sys);
      exp_step(1'b1 ^ dir_inv, 3'h0);
      exp_step(1'b1 ^ dir_inv, 3'h0);
      mcu.step_pin(1'b1, 2'h3);
      wr_reg(4'h2, 8'h18);
      // Freeze before the soft step can run; it must wait for the enable
      i_ce <= 1'b0;
      repeat (10) @(posedge i_clk_sys);
      cmp(11'(pos_q.size()), 11'h1, "step taken while frozen");
      i_ce <= 1'b1;
      repeat (8) @(posedge i_clk_sys);
      cmp({10'h0, o_bridge_drive}, 11'h0, "bridge off");
      wr_reg(4'h0, 8'h01);
      repeat (3) @(posedge i_clk_sys);
      cmp({10'h0, o_bridge_drive}, 11'h1, "bridge on");
      wr_reg(4'h0, 8'h11);
      repeat (3) @(posedge i_clk_sys);
      cmp({10'h0, o_bridge_drive}, 11'h0, "bridge in sleep");
      mcu.step_pin(1'b1, 2'h0);
      mcu.set_rh(1'b0);
      mcu.set_rh(1'b1);
      wr_reg(4'h0, 8'h05);
      mcu.step_pin(1'b0, 2'h0);
      rd_reg(4'h4, {1'b0, pos_exp});
      rd_reg(4'h3, 8'h11);
      mcu.set_rh(1'b0);
      rd_reg(4'h3, 8'h18);
      wr_reg(4'h1, 8'h0f);
      wait_pwm();
      cmp(o_target_ma, 11'd800, "run current");
      wr_reg(4'h0, 8'h0d);
      wait_pwm();
      cmp(o_target_ma, 11'd1100, "boosted current");
      rd_reg(4'h3, 8'h0c);
      i_thermal_warning <= 1'b1;
      wait_pwm();
      cmp(o_target_ma, 11'd800, "boost dropped");
      rd_reg(4'h3, 8'h08);
      wr_reg(4'h1, 8'hf0);
      mcu.set_rh(1'b1);
      wait_pwm();
      cmp(o_target_ma, 11'd673, "hold current");
      cmp({9'h0, o_diag_enable, o_duty_zero}, 11'h2, "diag on");
      wr_reg(4'h1, 8'h00);
      wait_pwm();
      cmp(o_target_ma, 11'd0, "zero hold");
      cmp({9'h0, o_diag_enable, o_duty_zero}, 11'h1, "diag off");
      repeat (5) @(posedge i_clk_sys);
      cmp(11'(pos_q.size()), 11'h0, "steps missing");
      close_out();
   end

   initial begin
      repeat (60000) @(posedge i_clk_sys);
      error_cnt++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      close_out();
   end
endmodule
